// >>> src/cbu_branch_unit.sv
/*
  Conditional branch unit: evaluates a branch condition, forms the next
  program counter, the state count and the side effects on carry, the
  tested bit and the decremented operand, one cycle after a request.
  Assumes the pipeline presents operands and flags with the request
  strobe and that only flag branches use the mode-based default counts.
*/
// Functional notes
// - Advance PC by length, then add displacement if the condition holds.
// - Each branch has a short not-taken and a longer taken state count.
// - Internal execution, taken to odd internal address: one extra state.
// - Unsigned greater, less-equal, equal, not equal, carry set and clear.
// - Signed less, less-equal, greater, greater-equal from sign and overflow.
// - Flag branches: binary 3 bytes 2/5 states; source 2 bytes 1/4; carry branches 2 bytes 1/4 in both modes.
// - Branch on bit set branches only when the bit reads one.
// - Branch on bit clear branches only when the bit reads zero.
// - Bit and clear: bit one clears it and branches, else nothing.
// - Compare sets carry when first below second; branches when unequal.
// - Decrement operand by one, branch when result is nonzero.
// - First note: plus one state for port, two for peripheral register.
// - Second note: plus two states for port, three for peripheral.
`include "cbu_map.svh"

module cbu_branch_unit #(
  parameter int PC_W = `CBU_PC_W,
  parameter int OP_W = `CBU_OP_W
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Request from the pipeline.
  input wire logic req_valid,
  input wire cbu_pkg::cbu_req_t req,
  input wire logic [PC_W-1:0] pc,
  input wire cbu_pkg::cbu_flags_t flags,
  input wire logic [OP_W-1:0] acc,
  input wire logic [OP_W-1:0] opnd_a,
  input wire logic [OP_W-1:0] opnd_b,
  input wire logic test_bit,
  input wire logic dest_internal,
  // Result to the pipeline.
  output logic resp_valid,
  output cbu_pkg::cbu_resp_t resp
);

  logic cond_true;
  logic [OP_W-1:0] dec_value;
  logic [2:0] len_eff;
  logic [PC_W-1:0] pc_adv;
  logic [PC_W-1:0] pc_target;
  logic [`CBU_ST_W-1:0] nt_base;
  logic [`CBU_ST_W-1:0] tk_base;
  logic [`CBU_ST_W-1:0] note_add;
  logic [`CBU_ST_W-1:0] states_next;
  logic odd_extra;
  logic flag_form;

  // Decremented operand for decrement-and-branch.
  assign dec_value = opnd_a - {{(OP_W-1){1'b0}}, 1'b1};

  // Condition evaluation for every branch kind.
  always_comb begin
    case (req.cond)
      cbu_pkg::CBU_CARRY_SET: cond_true = flags.carry_flag;
      cbu_pkg::CBU_CARRY_CLEAR: cond_true = !flags.carry_flag;
      cbu_pkg::CBU_EQUAL: cond_true = flags.zero;
      cbu_pkg::CBU_NOT_EQUAL: cond_true = !flags.zero;
      cbu_pkg::CBU_UNS_GREATER: begin
        cond_true = !flags.carry_flag && !flags.zero;
      end
      cbu_pkg::CBU_UNS_LESS_EQUAL: begin
        cond_true = flags.carry_flag || flags.zero;
      end
      cbu_pkg::CBU_SGN_LESS: begin
        cond_true = flags.negative ^ flags.overflow;
      end
      cbu_pkg::CBU_SGN_LESS_EQUAL: begin
        cond_true = (flags.negative ^ flags.overflow) || flags.zero;
      end
      cbu_pkg::CBU_SGN_GREATER: begin
        cond_true = !(flags.negative ^ flags.overflow) && !flags.zero;
      end
      cbu_pkg::CBU_SGN_GREATER_EQUAL: begin
        cond_true = !(flags.negative ^ flags.overflow);
      end
      cbu_pkg::CBU_BIT_SET: cond_true = test_bit;
      cbu_pkg::CBU_BIT_CLEAR: cond_true = !test_bit;
      cbu_pkg::CBU_BIT_AND_CLEAR: cond_true = test_bit;
      cbu_pkg::CBU_ACC_ZERO: cond_true = (acc == '0);
      cbu_pkg::CBU_ACC_NONZERO: cond_true = (acc != '0);
      cbu_pkg::CBU_COMPARE: cond_true = (opnd_a != opnd_b);
      cbu_pkg::CBU_DECREMENT: cond_true = (dec_value != '0);
      default: cond_true = 1'b0;
    endcase
  end

  // Flag branches other than carry take their length and counts from the execution mode.
  assign flag_form = (req.cond >= cbu_pkg::CBU_CARRY_SET) &&
                     (req.cond <= cbu_pkg::CBU_SGN_GREATER_EQUAL);

  always_comb begin
    if (req.cond == cbu_pkg::CBU_CARRY_SET ||
        req.cond == cbu_pkg::CBU_CARRY_CLEAR) begin
      len_eff = `CBU_CARRY_LEN;
      nt_base = `CBU_CARRY_NT;
      tk_base = `CBU_CARRY_TK;
    end else if (flag_form && req.source_mode) begin
      len_eff = `CBU_SRC_FLAG_LEN;
      nt_base = `CBU_SRC_FLAG_NT;
      tk_base = `CBU_SRC_FLAG_TK;
    end else if (flag_form) begin
      len_eff = `CBU_BIN_FLAG_LEN;
      nt_base = `CBU_BIN_FLAG_NT;
      tk_base = `CBU_BIN_FLAG_TK;
    end else begin
      len_eff = req.length;
      nt_base = req.base_not_taken;
      tk_base = req.base_taken;
    end
  end

  // Advance first, then add the sign-extended displacement.
  assign pc_adv = pc + {{(PC_W-3){1'b0}}, len_eff};
  assign pc_target = pc_adv +
                     {{(PC_W-OP_W){req.rel[OP_W-1]}}, req.rel};

  // Extra states for port or peripheral operands.
  always_comb begin
    note_add = '0;
    case (req.note)
      cbu_pkg::CBU_NOTE_ONE: begin
        if (req.opnd == cbu_pkg::CBU_OPND_PORT) begin
          note_add = `CBU_N1_PORT;
        end else if (req.opnd == cbu_pkg::CBU_OPND_PERIPH) begin
          note_add = `CBU_N1_PERIPH;
        end
      end
      cbu_pkg::CBU_NOTE_TWO: begin
        if (req.opnd == cbu_pkg::CBU_OPND_PORT) begin
          note_add = `CBU_N2_PORT;
        end else if (req.opnd == cbu_pkg::CBU_OPND_PERIPH) begin
          note_add = `CBU_N2_PERIPH;
        end
      end
      default: note_add = '0;
    endcase
  end

  // Odd internal destination costs a state under internal execution.
  assign odd_extra = cond_true && req.internal_exec && dest_internal &&
                     pc_target[0];

  always_comb begin
    if (cond_true) begin
      states_next = tk_base + note_add +
                    (odd_extra ? `CBU_ODD_EXTRA : 4'h0);
    end else begin
      states_next = nt_base + note_add;
    end
  end

  // Valid strobe of the answer.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= req_valid;
    end
  end

  // Answer contents, held until the next request.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resp <= '0;
    end else if (req_valid) begin
      resp.taken <= cond_true;
      resp.next_pc <= cond_true ? pc_target : pc_adv;
      resp.states <= states_next;
      resp.write_carry <= (req.cond == cbu_pkg::CBU_COMPARE);
      resp.carry_value <= (opnd_a < opnd_b);
      resp.write_bit <= (req.cond == cbu_pkg::CBU_BIT_AND_CLEAR) &&
                        test_bit;
      resp.write_opnd <= (req.cond == cbu_pkg::CBU_DECREMENT);
      resp.opnd_value <= dec_value;
    end
  end

  // Assertions share the core clock and rest while reset is held.
  default clocking a_clk @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Every request is answered by one strobe exactly a cycle later.
  a_answer_pulse: assert property (
    resp_valid == $past(req_valid))
    else $error("Answer strobe does not follow the request strobe.");

  // The answer stands unchanged until the next request.
  a_answer_holds: assert property (
    !req_valid |=> $stable(resp))
    else $error("Answer changed without a request.");

  // A not-taken branch only steps past the instruction.
  a_pc_advance: assert property (
    req_valid && !cond_true |=>
      resp.next_pc == $past(pc) + PC_W'($past(len_eff)))
    else $error("Not-taken branch did not advance by length.");

  // A taken branch adds the sign-extended offset to the advanced PC.
  a_rel_sign: assert property (
    req_valid && cond_true |=> resp.next_pc ==
      $past(pc_adv) + {{(PC_W-OP_W){$past(req.rel[OP_W-1])}},
      $past(req.rel)})
    else $error("Taken target not advanced PC plus signed offset.");

  // Flag branches: taken costs the fixed gap more, plus any odd state.
  a_taken_longer: assert property (
    req_valid && flag_form && req.note == cbu_pkg::CBU_NOTE_NONE |=>
      resp.states == (resp.taken ?
        $past(nt_base) + `CBU_TAKEN_GAP + {3'h0, $past(odd_extra)} :
        $past(nt_base)))
    else $error("Flag branch taken and not-taken counts differ wrongly.");

  // Binary flag branch to an odd internal target costs one more state.
  // Carry branches are left out, as their base count is lower.
  a_odd_extra: assert property (
    req_valid && flag_form && !req.source_mode && cond_true &&
      req.cond != cbu_pkg::CBU_CARRY_SET &&
      req.cond != cbu_pkg::CBU_CARRY_CLEAR &&
      req.note == cbu_pkg::CBU_NOTE_NONE && odd_extra
      |=> resp.states == `CBU_BIN_FLAG_TK + `CBU_ODD_EXTRA)
    else $error("Odd internal destination missed its extra state.");

  // Unsigned greater needs both carry and zero clear.
  a_uns_greater: assert property (
    req_valid && req.cond == cbu_pkg::CBU_UNS_GREATER |=>
      resp.taken == !($past(flags.carry_flag) || $past(flags.zero)))
    else $error("Unsigned greater evaluated wrongly.");

  // Signed less follows sign differing from overflow.
  a_sgn_less: assert property (
    req_valid && req.cond == cbu_pkg::CBU_SGN_LESS |=>
      resp.taken == ($past(flags.negative) != $past(flags.overflow)))
    else $error("Signed less evaluated wrongly.");

  // Source mode flag branch: two bytes, fixed short and long counts.
  a_src_counts: assert property (
    req_valid && req.cond == cbu_pkg::CBU_EQUAL && req.source_mode &&
      !odd_extra && req.note == cbu_pkg::CBU_NOTE_NONE |=>
      resp.states == (resp.taken ? `CBU_SRC_FLAG_TK : `CBU_SRC_FLAG_NT) &&
      (resp.taken ||
       resp.next_pc == $past(pc) + PC_W'(`CBU_SRC_FLAG_LEN)))
    else $error("Source mode flag branch counts wrong.");

  // Binary mode flag branch: three bytes, fixed short and long counts.
  a_bin_counts: assert property (
    req_valid && req.cond == cbu_pkg::CBU_NOT_EQUAL && !req.source_mode &&
      !odd_extra && req.note == cbu_pkg::CBU_NOTE_NONE |=>
      resp.states == (resp.taken ? `CBU_BIN_FLAG_TK : `CBU_BIN_FLAG_NT) &&
      (resp.taken ||
       resp.next_pc == $past(pc) + PC_W'(`CBU_BIN_FLAG_LEN)))
    else $error("Binary mode flag branch counts wrong.");

  // Bit tests follow the addressed bit; only bit-and-clear writes it.
  a_bit_set: assert property (
    req_valid && req.cond == cbu_pkg::CBU_BIT_SET
      |=> resp.taken == $past(test_bit) && !resp.write_bit)
    else $error("Bit set branch wrong.");
  a_bit_clear: assert property (
    req_valid && req.cond == cbu_pkg::CBU_BIT_CLEAR
      |=> resp.taken != $past(test_bit))
    else $error("Bit clear branch wrong.");
  a_bit_and_clr: assert property (
    req_valid && req.cond == cbu_pkg::CBU_BIT_AND_CLEAR
      |=> resp.write_bit == $past(test_bit) &&
          resp.taken == $past(test_bit))
    else $error("Bit and clear side effect wrong.");

  // Compare writes carry from the unsigned order, branches when unequal.
  a_compare_cy: assert property (
    req_valid && req.cond == cbu_pkg::CBU_COMPARE |=> resp.write_carry &&
      resp.carry_value == ($past(opnd_a) < $past(opnd_b)) &&
      resp.taken == ($past(opnd_a) != $past(opnd_b)))
    else $error("Compare carry or branch wrong.");

  // No other branch may disturb the carry flag.
  a_carry_write: assert property (
    req_valid && req.cond != cbu_pkg::CBU_COMPARE |=> !resp.write_carry)
    else $error("Carry written by a branch other than compare.");

  // Decrement hands back the reduced operand and branches on nonzero.
  a_decrement_branch: assert property (
    req_valid && req.cond == cbu_pkg::CBU_DECREMENT |=> resp.write_opnd &&
      resp.opnd_value == $past(opnd_a) - 8'h01 &&
      resp.taken == (resp.opnd_value != 8'h00))
    else $error("Decrement and branch wrong.");

  // Note adders on the not-taken count.
  a_note_one: assert property (
    req_valid && req.note == cbu_pkg::CBU_NOTE_ONE &&
      req.opnd == cbu_pkg::CBU_OPND_PERIPH && !cond_true
      |=> resp.states == $past(nt_base) + 4'h2)
    else $error("First note adder wrong.");
  a_note_two: assert property (
    req_valid && req.note == cbu_pkg::CBU_NOTE_TWO &&
      req.opnd == cbu_pkg::CBU_OPND_PORT && !cond_true
      |=> resp.states == $past(nt_base) + 4'h2)
    else $error("Second note adder wrong.");

  // Main scenarios.
  c_taken: cover property (@(posedge sys_clk) disable iff (!reset_n)
    req_valid && cond_true ##1 resp_valid);
  c_odd: cover property (@(posedge sys_clk) disable iff (!reset_n)
    req_valid && odd_extra);
  c_bit_clear: cover property (@(posedge sys_clk) disable iff (!reset_n)
    req_valid && req.cond == cbu_pkg::CBU_BIT_AND_CLEAR && test_bit);
  c_dec_zero: cover property (@(posedge sys_clk) disable iff (!reset_n)
    req_valid && req.cond == cbu_pkg::CBU_DECREMENT && !cond_true);
  c_cmp_below: cover property (@(posedge sys_clk) disable iff (!reset_n)
    req_valid && req.cond == cbu_pkg::CBU_COMPARE && opnd_a < opnd_b);

endmodule

// >>> src/cbu_map.svh
/*
  Constants of the conditional branch unit: widths, instruction
  lengths, state counts and extra-state adders.
  Assumes it is included by bare name from the package and the module.
*/
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH

`define CBU_PC_W 24
`define CBU_OP_W 8
`define CBU_ST_W 4

// Base state counts and lengths of the flag-conditioned branches.
`define CBU_BIN_FLAG_NT 4'h2
`define CBU_BIN_FLAG_TK 4'h5
`define CBU_SRC_FLAG_NT 4'h1
`define CBU_SRC_FLAG_TK 4'h4
`define CBU_CARRY_NT 4'h1
`define CBU_CARRY_TK 4'h4
`define CBU_BIN_FLAG_LEN 3'h3
`define CBU_SRC_FLAG_LEN 3'h2
`define CBU_CARRY_LEN 3'h2
`define CBU_TAKEN_GAP 4'h3

// Extra states for I/O port and peripheral register operands and for odd internal targets.
`define CBU_N1_PORT 4'h1
`define CBU_N1_PERIPH 4'h2
`define CBU_N2_PORT 4'h2
`define CBU_N2_PERIPH 4'h3
`define CBU_ODD_EXTRA 4'h1

`endif

// >>> src/cbu_pkg.sv
/*
  Types of the conditional branch unit.
  Assumes cbu_map.svh is on the include path.
*/
`include "cbu_map.svh"

package cbu_pkg;

  // Branch conditions evaluated by the unit.
  typedef enum logic [4:0] {
    CBU_NONE = 5'h00,
    CBU_CARRY_SET = 5'h01,
    CBU_CARRY_CLEAR = 5'h02,
    CBU_EQUAL = 5'h03,
    CBU_NOT_EQUAL = 5'h04,
    CBU_UNS_GREATER = 5'h05,
    CBU_UNS_LESS_EQUAL = 5'h06,
    CBU_SGN_LESS = 5'h07,
    CBU_SGN_LESS_EQUAL = 5'h08,
    CBU_SGN_GREATER = 5'h09,
    CBU_SGN_GREATER_EQUAL = 5'h0a,
    CBU_BIT_SET = 5'h0b,
    CBU_BIT_CLEAR = 5'h0c,
    CBU_BIT_AND_CLEAR = 5'h0d,
    CBU_ACC_ZERO = 5'h0e,
    CBU_ACC_NONZERO = 5'h0f,
    CBU_COMPARE = 5'h10,
    CBU_DECREMENT = 5'h11
  } cbu_cond_t;

  // Kind of operand addressed, for the state adders.
  typedef enum logic [1:0] {
    CBU_OPND_PLAIN = 2'h0,
    CBU_OPND_PORT = 2'h1,
    CBU_OPND_PERIPH = 2'h2
  } cbu_opnd_t;

  // Which extra-state note applies to the instruction.
  typedef enum logic [1:0] {
    CBU_NOTE_NONE = 2'h0,
    CBU_NOTE_ONE = 2'h1,
    CBU_NOTE_TWO = 2'h2
  } cbu_note_t;

  // Status flags seen by the branch.
  typedef struct packed {
    logic carry_flag;
    logic zero;
    logic negative;
    logic overflow;
  } cbu_flags_t;

  // One branch request from the execution pipeline.
  typedef struct packed {
    cbu_cond_t cond;
    logic source_mode;
    logic internal_exec;
    logic [2:0] length;
    logic [`CBU_ST_W-1:0] base_not_taken;
    logic [`CBU_ST_W-1:0] base_taken;
    cbu_note_t note;
    cbu_opnd_t opnd;
    logic [`CBU_OP_W-1:0] rel;
  } cbu_req_t;

  // Result handed back to the pipeline.
  typedef struct packed {
    logic taken;
    logic [`CBU_PC_W-1:0] next_pc;
    logic [`CBU_ST_W-1:0] states;
    logic write_carry;
    logic carry_value;
    logic write_bit;
    logic write_opnd;
    logic [`CBU_OP_W-1:0] opnd_value;
  } cbu_resp_t;

endpackage

// >>> test/cbu_pipe_model.sv
/*
  Pipeline model: holds the tested bit and the first operand that the
  unit reads, and applies the unit's write-backs to them.
  Assumes the bench loads it only while no answer is pending.
*/
module cbu_pipe_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Loads from the bench.
  input wire logic load,
  input wire logic load_bit,
  input wire logic [7:0] load_opnd,
  // Result from the unit.
  input wire logic resp_valid,
  input wire cbu_pkg::cbu_resp_t resp,
  // Operands to the unit.
  output logic test_bit,
  output logic [7:0] opnd_a
);
  timeunit 1ns;
  timeprecision 1ps;

  // Write-backs land at the edge after the answer, as in the core.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      test_bit <= 1'b0;
      opnd_a <= 8'h00;
    end else if (load) begin
      test_bit <= load_bit;
      opnd_a <= load_opnd;
    end else if (resp_valid) begin
      if (resp.write_bit) test_bit <= 1'b0;
      if (resp.write_opnd) opnd_a <= resp.opnd_value;
    end
  end
endmodule

// >>> test/conditional_branch_unit_tb_top.sv
/*
  Bench of the conditional branch unit: sends requests and checks each
  answer against figures worked out here.
  Assumes cbu_pkg, the unit and the pipeline model are compiled first.
*/
module conditional_branch_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  cbu_pkg::cbu_req_t req = '0;
  logic [23:0] pc = 24'h000000;
  cbu_pkg::cbu_flags_t flags = '0;
  logic [7:0] acc = 8'h00;
  logic [7:0] opnd_b = 8'h00;
  logic dest_internal = 1'b0;
  logic load = 1'b0;
  logic load_bit = 1'b0;
  logic [7:0] load_opnd = 8'h00;
  logic test_bit;
  logic [7:0] opnd_a;
  logic resp_valid;
  cbu_pkg::cbu_resp_t resp;
  int bad_count = 0;
  int comparisons = 0;

  // Clock of 4 ns period.
  always #2 sys_clk = ~sys_clk;

  cbu_branch_unit i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .pc(pc), .flags(flags), .acc(acc),
    .opnd_a(opnd_a), .opnd_b(opnd_b), .test_bit(test_bit),
    .dest_internal(dest_internal), .resp_valid(resp_valid), .resp(resp));

  cbu_pipe_model i_pipe (.sys_clk(sys_clk), .reset_n(reset_n),
    .load(load), .load_bit(load_bit), .load_opnd(load_opnd),
    .resp_valid(resp_valid), .resp(resp), .test_bit(test_bit),
    .opnd_a(opnd_a));

  // Counts a comparison and reports a mismatch.
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Builds a request; the fixed length and counts serve non-flag kinds.
  function automatic cbu_pkg::cbu_req_t mk(cbu_pkg::cbu_cond_t c,
      logic src, logic [7:0] rel, logic [1:0] note, logic [1:0] od);
    mk = '0;
    mk.cond = c;
    mk.source_mode = src;
    mk.rel = rel;
    mk.length = 3'h3;
    mk.base_not_taken = 4'h2;
    mk.base_taken = 4'h5;
    mk.note = cbu_pkg::cbu_note_t'(note);
    mk.opnd = cbu_pkg::cbu_opnd_t'(od);
    mk.internal_exec = 1'b1;
  endfunction

  // Condition of flag branch k under flags f = {carry, zero, neg, ovf}.
  function automatic logic holds(int k, logic [3:0] f);
    logic lt;
    lt = f[1] ^ f[0];
    case (k)
      0: holds = f[3];
      1: holds = !f[3];
      2: holds = f[2];
      3: holds = !f[2];
      4: holds = !f[3] && !f[2];
      5: holds = f[3] || f[2];
      6: holds = lt;
      7: holds = lt || f[2];
      8: holds = !(lt || f[2]);
      default: holds = !lt;
    endcase
  endfunction

  // Presents one request for one cycle and waits for its answer.
  task automatic send(cbu_pkg::cbu_req_t r, logic [23:0] p, logic [3:0] f,
      logic [7:0] a, logic [7:0] b, logic di);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= r;
    pc <= p;
    flags <= cbu_pkg::cbu_flags_t'(f);
    acc <= a;
    opnd_b <= b;
    dest_internal <= di;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    check(64'(resp_valid), 64'h1);
  endtask

  // Compares outcome, next address and state count with the figures.
  task automatic expect_br(logic tk, logic [23:0] p, logic [2:0] len,
      logic [7:0] rel, logic [3:0] st);
    logic [23:0] tgt;
    tgt = p + 24'(len) + (tk ? {{16{rel[7]}}, rel} : 24'h000000);
    check(64'(resp.taken), 64'(tk));
    check(64'(resp.next_pc), 64'(tgt));
    check(64'(resp.states), 64'(st));
  endtask

  // One non-flag request with length 3 and counts 2/5.
  task automatic one(cbu_pkg::cbu_cond_t c, logic [7:0] a, logic [7:0] b,
      logic tk);
    send(mk(c, 1'b0, 8'hf0, 2'h0, 2'h0), 24'h003000, 4'h0, a, b, 1'b0);
    expect_br(tk, 24'h003000, 3'h3, 8'hf0, tk ? 4'h5 : 4'h2);
  endtask

  // Loads the tested bit and the first operand into the model.
  task automatic load_model(logic b, logic [7:0] v);
    @(posedge sys_clk);
    load <= 1'b1;
    load_bit <= b;
    load_opnd <= v;
    @(posedge sys_clk);
    load <= 1'b0;
  endtask

  // Every flag branch under every flag set, in both modes.
  task automatic t_flags();
    logic tk;
    logic [7:0] rel;
    logic [2:0] len;
    logic [3:0] st;
    logic [23:0] p;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 10; k++) begin
        for (int f = 0; f < 16; f++) begin
          rel = 8'(f * 37 + k);
          p = 24'h001000 + 24'(f);
          tk = holds(k, f[3:0]);
          len = (k < 2 || m == 1) ? 3'h2 : 3'h3;
          st = ((k < 2 || m == 1) ? 4'h1 : 4'h2) + (tk ? 4'h3 : 4'h0);
          send(mk(cbu_pkg::cbu_cond_t'(k + 1), m[0], rel, 2'h0, 2'h0), p,
            f[3:0], 8'h00, 8'h00, 1'b0);
          expect_br(tk, p, len, rel, st);
        end
      end
    end
  endtask

  // Extra state only when taken, internal and to an odd internal target.
  task automatic t_odd();
    cbu_pkg::cbu_req_t r;
    r = mk(cbu_pkg::CBU_EQUAL, 1'b0, 8'h02, 2'h0, 2'h0);
    send(r, 24'h002000, 4'h4, 8'h00, 8'h00, 1'b1);
    expect_br(1'b1, 24'h002000, 3'h3, 8'h02, 4'h6);
    send(r, 24'h002000, 4'h4, 8'h00, 8'h00, 1'b0);
    expect_br(1'b1, 24'h002000, 3'h3, 8'h02, 4'h5);
    send(r, 24'h002000, 4'h0, 8'h00, 8'h00, 1'b1);
    expect_br(1'b0, 24'h002000, 3'h3, 8'h02, 4'h2);
    r.internal_exec = 1'b0;
    send(r, 24'h002000, 4'h4, 8'h00, 8'h00, 1'b1);
    expect_br(1'b1, 24'h002000, 3'h3, 8'h02, 4'h5);
  endtask

  // Bit tests with a clear that the model applies, then accumulator tests.
  task automatic t_bits();
    load_model(1'b1, 8'h00);
    one(cbu_pkg::CBU_BIT_SET, 8'h00, 8'h00, 1'b1);
    one(cbu_pkg::CBU_BIT_CLEAR, 8'h00, 8'h00, 1'b0);
    one(cbu_pkg::CBU_BIT_AND_CLEAR, 8'h00, 8'h00, 1'b1);
    check(64'(resp.write_bit), 64'h1);
    check(64'(resp.write_carry), 64'h0);
    one(cbu_pkg::CBU_BIT_SET, 8'h00, 8'h00, 1'b0);
    one(cbu_pkg::CBU_BIT_CLEAR, 8'h00, 8'h00, 1'b1);
    one(cbu_pkg::CBU_BIT_AND_CLEAR, 8'h00, 8'h00, 1'b0);
    check(64'(resp.write_bit), 64'h0);
    one(cbu_pkg::CBU_ACC_ZERO, 8'h00, 8'h00, 1'b1);
    one(cbu_pkg::CBU_ACC_ZERO, 8'h01, 8'h00, 1'b0);
    one(cbu_pkg::CBU_ACC_NONZERO, 8'h80, 8'h00, 1'b1);
    one(cbu_pkg::CBU_ACC_NONZERO, 8'h00, 8'h00, 1'b0);
  endtask

  // Compare: carry from the unsigned order, branch when unequal.
  task automatic t_cmp();
    logic [17:0] tab [4];
    tab = '{{8'h10, 8'h20, 2'b11}, {8'h20, 8'h10, 2'b01},
      {8'h33, 8'h33, 2'b00}, {8'h80, 8'h7f, 2'b01}};
    for (int i = 0; i < 4; i++) begin
      load_model(1'b0, tab[i][17:10]);
      one(cbu_pkg::CBU_COMPARE, 8'h00, tab[i][9:2], tab[i][0]);
      check(64'(resp.write_carry), 64'h1);
      check(64'(resp.carry_value), 64'(tab[i][1]));
      check(64'(resp.write_opnd), 64'h0);
    end
  endtask

  // Decrement from 2 through 0 to ff, the model keeping the result.
  task automatic t_dec();
    logic [7:0] v;
    load_model(1'b0, 8'h02);
    for (int i = 0; i < 3; i++) begin
      v = 8'h01 - 8'(i);
      one(cbu_pkg::CBU_DECREMENT, 8'h00, 8'h00, v != 8'h00);
      check(64'(resp.write_opnd), 64'h1);
      check(64'(resp.opnd_value), 64'(v));
    end
  endtask

  // Extra states of both notes for each operand kind, taken or not.
  task automatic t_notes();
    logic [3:0] add;
    for (int b = 0; b < 2; b++) begin
      load_model(b[0], 8'h00);
      for (int n = 0; n < 3; n++) begin
        for (int o = 0; o < 3; o++) begin
          add = (n == 1) ? 4'(o) : (n == 2 && o > 0) ? 4'(o + 1) : 4'h0;
          send(mk(cbu_pkg::CBU_BIT_SET, 1'b0, 8'h10, 2'(n), 2'(o)),
            24'h004000, 4'h0, 8'h00, 8'h00, 1'b0);
          expect_br(b[0], 24'h004000, 3'h3, 8'h10,
            (b == 1 ? 4'h5 : 4'h2) + add);
        end
      end
    end
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge sys_clk);
    check(64'(resp_valid), 64'h0);
    check(64'(resp.taken), 64'h0);
    reset_n <= 1'b1;
    t_flags();
    t_odd();
    t_bits();
    t_cmp();
    t_dec();
    t_notes();
    final_report();
  end

  // Watchdog well beyond the expected run of some 740 cycles.
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
endmodule
